// ### src/tvc_ctrl.sv
// Two-level vectored interrupt controller facing the core sequencer.
`timescale 1ns/1ps
`include "tvc_regs.svh"

module tvc_ctrl
  import tvc_pkg::*;
(
  input wire logic i_core_clk, // System clock, 20 MHz.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic [7:0] i_sfr_addr, // Special register address.
  input wire logic i_sfr_we, // Register write strobe.
  input wire logic i_sfr_re, // Register read strobe.
  input wire logic [7:0] i_sfr_wdata, // Register write data.
  output logic [7:0] o_sfr_rdata, // Read data, valid cycle after strobe.
  input wire tvc_pend_s i_pend, // Peripheral pending flags.
  input wire logic i_instr_end, // Current instruction completes.
  input wire logic i_return_from_service, // Return from service completes.
  output logic o_call_start, // First cycle of a vector call.
  output logic o_call_active, // Vector call in progress.
  output logic [15:0] o_vec_addr, // Service address of the call.
  output logic [3:0] o_flag_clear, // Auto-clear of ext0, tmr0, ext1, tmr1.
  output logic [1:0] o_in_service // Bit 1 high level, bit 0 low level.
);

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  tvc_state_s s_reg;
  tvc_state_s s_next;

  logic [11:0] raw;
  logic [11:0] en;
  logic [11:0] lvl;
  logic [11:0] hi_ok;
  logic [11:0] lo_ok;
  logic [3:0] pick;
  logic pick_hi;
  logic pick_vld;
  logic launch;

  //----------------------------------------------------------------------------
  // Request formation
  //----------------------------------------------------------------------------
  // A flag set by software reaches here exactly as a hardware flag does.
  always_comb begin
    raw[0] = i_pend.ext_input_zero;
    raw[1] = i_pend.timer0;
    raw[2] = i_pend.ext_input_one;
    raw[3] = i_pend.timer1;
    raw[4] = i_pend.serial_rx | i_pend.serial_tx;
    raw[5] = i_pend.timer2_low_overflow_flag | i_pend.timer2_high_overflow_flag;
    raw[6] = i_pend.twowire;
    raw[7] = i_pend.conv_window;
    raw[8] = i_pend.conv_done;
    raw[9] = i_pend.pca_overflow | (|i_pend.pca_match);
    raw[10] = i_pend.cmp_fall;
    raw[11] = i_pend.cmp_rise;
  end

  // Disabled sources keep their flags but are ignored.
  assign en = {s_reg.mask_ext, s_reg.mask[5:0]}
    & {12{s_reg.mask[`TVC_BIT_GLOBAL]}};
  assign lvl = {s_reg.pri_ext, s_reg.pri_base};

  //----------------------------------------------------------------------------
  // Arbitration
  //----------------------------------------------------------------------------
  // A high request may enter only while no high routine runs; a low one
  // only while nothing runs at all.
  assign hi_ok = s_reg.req & lvl & {12{~s_reg.act_hi}};
  assign lo_ok = s_reg.req & ~lvl
    & {12{~s_reg.act_hi & ~s_reg.act_lo}};

  always_comb begin
    pick = 4'h0;
    pick_hi = 1'b0;
    pick_vld = 1'b0;
    if (|hi_ok) begin
      pick_hi = 1'b1;
      pick_vld = 1'b1;
      for (int i = 11; i >= 0; i--) begin
        if (hi_ok[i]) begin
          pick = 4'(i);
        end
      end
    end else if (|lo_ok) begin
      pick_vld = 1'b1;
      for (int i = 11; i >= 0; i--) begin
        if (lo_ok[i]) begin
          pick = 4'(i);
        end
      end
    end
  end

  // The call waits for the running instruction to end, and never on the
  // boundary of a return, so one more instruction always runs first.
  assign launch = pick_vld && (s_reg.st == TVC_IDLE)
    && i_instr_end && !i_return_from_service;

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.req = raw & en;
    s_next.start = 1'b0;
    s_next.clr = 4'h0;

    if (i_sfr_we) begin
      case (i_sfr_addr)
        `TVC_ADDR_MASK: begin
          s_next.mask = i_sfr_wdata;
        end
        `TVC_ADDR_PRI_BASE: begin
          s_next.pri_base = i_sfr_wdata[5:0];
        end
        `TVC_ADDR_MASK_EXT: begin
          s_next.mask_ext = i_sfr_wdata[5:0];
        end
        `TVC_ADDR_PRI_EXT: begin
          s_next.pri_ext = i_sfr_wdata[5:0];
        end
        default: begin
        end
      endcase
    end

    // Judge the level with the priorities that arbitration will see next.
    s_next.hi_req = |(raw & en & {s_next.pri_ext, s_next.pri_base});

    if (i_sfr_re) begin
      case (i_sfr_addr)
        `TVC_ADDR_MASK: begin
          s_next.rdata = s_reg.mask;
        end
        `TVC_ADDR_PRI_BASE: begin
          s_next.rdata = {`TVC_PRI_UNUSED, s_reg.pri_base};
        end
        `TVC_ADDR_MASK_EXT: begin
          s_next.rdata = {`TVC_MASK_EXT_UNUSED, s_reg.mask_ext};
        end
        `TVC_ADDR_PRI_EXT: begin
          s_next.rdata = {`TVC_PRI_UNUSED, s_reg.pri_ext};
        end
        default: begin
          s_next.rdata = 8'h00;
        end
      endcase
    end

    // A return ends the innermost routine, which is the high one if any.
    if (i_return_from_service) begin
      if (s_reg.act_hi) begin
        s_next.act_hi = 1'b0;
      end else begin
        s_next.act_lo = 1'b0;
      end
    end

    case (s_reg.st)
      TVC_IDLE: begin
        if (launch) begin
          s_next.st = TVC_CALL;
          s_next.cnt = `TVC_CALL_CYC - 3'h1;
          s_next.start = 1'b1;
          s_next.vec = `TVC_VEC_BASE + {9'h000, pick, 3'h0};
          if (pick_hi) begin
            s_next.act_hi = 1'b1;
          end else begin
            s_next.act_lo = 1'b1;
          end
          if (pick < 4'h4) begin
            s_next.clr = 4'h1 << pick[1:0];
          end
        end
      end
      TVC_CALL: begin
        if (s_reg.cnt == 3'h0) begin
          s_next.st = TVC_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt - 3'h1;
        end
      end
      default: begin
        s_next.st = TVC_IDLE;
      end
    endcase
  end

  //----------------------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------------------
  // Reset clears everything: levels low, masks off, vector at zero.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_reg.mask <= `TVC_RST_MASK;
      s_reg.pri_base <= `TVC_RST_PRI;
      s_reg.mask_ext <= `TVC_RST_MASK_EXT;
      s_reg.pri_ext <= `TVC_RST_PRI;
      s_reg.req <= 12'h000;
      s_reg.hi_req <= 1'b0;
      s_reg.act_hi <= 1'b0;
      s_reg.act_lo <= 1'b0;
      s_reg.st <= TVC_IDLE;
      s_reg.cnt <= 3'h0;
      s_reg.start <= 1'b0;
      s_reg.vec <= `TVC_RST_VEC;
      s_reg.clr <= 4'h0;
      s_reg.rdata <= 8'h00;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_sfr_rdata = s_reg.rdata;
  assign o_call_start = s_reg.start;
  assign o_call_active = (s_reg.st == TVC_CALL);
  assign o_vec_addr = s_reg.vec;
  assign o_flag_clear = s_reg.clr;
  assign o_in_service = {s_reg.act_hi, s_reg.act_lo};

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_call_body;
    o_call_active [*4] ##1 !o_call_active;
  endsequence

  property p_call_len;
    o_call_start |-> s_call_body;
  endproperty
  a_call_len: assert property (p_call_len)
    else $error("vector call did not last four cycles");

  property p_vec_range;
    o_call_start |-> (o_vec_addr[2:0] == 3'h3)
      && (o_vec_addr >= `TVC_VEC_BASE) && (o_vec_addr <= `TVC_VEC_LAST);
  endproperty
  a_vec_range: assert property (p_vec_range)
    else $error("vector address off the source table");

  property p_return_from_service_gap;
    i_return_from_service |=> !o_call_start;
  endproperty
  a_return_from_service_gap: assert property (p_return_from_service_gap)
    else $error("call made on the return boundary");

  property p_hi_hold;
    (o_in_service[1] && !o_call_active) |=> !o_call_start;
  endproperty
  a_hi_hold: assert property (p_hi_hold)
    else $error("high routine was preempted");

  property p_global_off;
    o_call_start |-> $past(s_reg.mask[`TVC_BIT_GLOBAL], 2);
  endproperty
  a_global_off: assert property (p_global_off)
    else $error("call taken with global enable off");

  property p_auto_clear;
    o_call_start |-> ((o_flag_clear != 4'h0) == (o_vec_addr < 16'h0023));
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("auto clear does not match source");

  property p_boundary;
    o_call_start |-> $past(i_instr_end);
  endproperty
  a_boundary: assert property (p_boundary)
    else $error("call started off an instruction boundary");

  sequence s_hi_wait;
    s_reg.hi_req && !o_in_service[1];
  endsequence

  property p_hi_first;
    s_hi_wait ##1 o_call_start |-> o_in_service[1];
  endproperty
  a_hi_first: assert property (p_hi_first)
    else $error("low request won over a high one");

  // A clear pulse must never reach a peripheral outside a call start.
  property p_clear_with_start;
    (o_flag_clear != 4'h0) |-> o_call_start;
  endproperty
  a_clear_with_start: assert property (p_clear_with_start)
    else $error("flag clear outside a call start");

  property p_clear_map;
    (o_call_start && (o_vec_addr < 16'h0023))
      |-> (o_flag_clear == (4'h1 << o_vec_addr[4:3]));
  endproperty
  a_clear_map: assert property (p_clear_map)
    else $error("flag clear sent to the wrong source");

  property p_start_from_idle;
    o_call_start |-> !$past(o_call_active);
  endproperty
  a_start_from_idle: assert property (p_start_from_idle)
    else $error("call started inside another call");

  property p_vec_hold;
    !o_call_start |-> $stable(o_vec_addr);
  endproperty
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector address moved outside a call start");

  sequence s_lo_running;
    o_in_service == 2'b01;
  endsequence

  property p_lo_preempt;
    s_lo_running ##1 o_call_start |-> (o_in_service == 2'b11);
  endproperty
  a_lo_preempt: assert property (p_lo_preempt)
    else $error("low routine entered by a low request");

  sequence s_hi_return;
    i_return_from_service && o_in_service[1];
  endsequence

  property p_hi_return;
    s_hi_return |=> (!o_in_service[1] && $stable(o_in_service[0]));
  endproperty
  a_hi_return: assert property (p_hi_return)
    else $error("return did not end the high routine");

  property p_lo_return;
    (i_return_from_service && (o_in_service == 2'b01)) |=> (o_in_service == 2'b00);
  endproperty
  a_lo_return: assert property (p_lo_return)
    else $error("return did not end the low routine");

  property p_pri_read;
    (i_sfr_re && ((i_sfr_addr == `TVC_ADDR_PRI_BASE)
      || (i_sfr_addr == `TVC_ADDR_PRI_EXT)))
      |=> (o_sfr_rdata[7:6] == `TVC_PRI_UNUSED);
  endproperty
  a_pri_read: assert property (p_pri_read)
    else $error("unused priority bits read wrong");

  property p_ext_read;
    (i_sfr_re && (i_sfr_addr == `TVC_ADDR_MASK_EXT))
      |=> (o_sfr_rdata[7:6] == `TVC_MASK_EXT_UNUSED);
  endproperty
  a_ext_read: assert property (p_ext_read)
    else $error("unused mask bits read wrong");

  // Reserved addresses must read as zero so software sees no ghost state.
  property p_unmapped_read;
    (i_sfr_re && (i_sfr_addr != `TVC_ADDR_MASK) && (i_sfr_addr != `TVC_ADDR_PRI_BASE)
      && (i_sfr_addr != `TVC_ADDR_MASK_EXT) && (i_sfr_addr != `TVC_ADDR_PRI_EXT))
      |=> (o_sfr_rdata == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("reserved address read not zero");

endmodule : tvc_ctrl

// ### src/tvc_pkg.sv
// Types shared by the vectored interrupt controller.
package tvc_pkg;

  typedef enum logic {
    TVC_IDLE = 1'b0,
    TVC_CALL = 1'b1
  } tvc_st_e;

  // Raw pending flags as held by the peripherals.
  typedef struct packed {
    logic cmp_rise;
    logic cmp_fall;
    logic [2:0] pca_match;
    logic pca_overflow;
    logic conv_done;
    logic conv_window;
    logic twowire;
    logic timer2_high_overflow_flag;
    logic timer2_low_overflow_flag;
    logic serial_tx;
    logic serial_rx;
    logic timer1;
    logic ext_input_one;
    logic timer0;
    logic ext_input_zero;
  } tvc_pend_s;

  typedef struct packed {
    logic [7:0] mask;
    logic [5:0] pri_base;
    logic [5:0] mask_ext;
    logic [5:0] pri_ext;
    logic [11:0] req;
    logic hi_req;
    logic act_hi;
    logic act_lo;
    tvc_st_e st;
    logic [2:0] cnt;
    logic start;
    logic [15:0] vec;
    logic [3:0] clr;
    logic [7:0] rdata;
  } tvc_state_s;

endpackage : tvc_pkg

// ### src/tvc_regs.svh
// Register offsets, reset values and timing counts of the vectored interrupt controller.
//------------------------------------------------------------------------------
// Behaviour
// - Twelve sources, each with flags, enable, priority.
// - Software-set pending flag requests like hardware.
// - Each source selects low or high level.
// - High request may preempt low service routine.
// - Nothing preempts a high service routine.
// - All priority bits reset to low.
// - Level comes from two priority registers.
// - Simultaneous mixed levels: high serviced first.
// - Same level: fixed order, lowest number first.
// - Reset vector zero; sources at 0x0003 plus eight.
// - Requests sampled and resolved every clock.
// - Best response: one detect plus four call.
// - After return, one instruction before next call.
// - Worst response eighteen clocks without competing service.
// - Equal or lower level waits for return.
// - Global enable bit seven gates every source.
// - Enable bit six is a plain software flag.
// - Enable bit five masks timer 2 overflows.
// - Enable bits zero to four mask base sources.
// - Flags set regardless of enable; ignored if off.
// - External and timer 0/1 flags cleared on vectoring.
// - Flag still set after return requests again.
// - Call taken only at instruction completion.
//------------------------------------------------------------------------------
`ifndef TVC_REGS_SVH
`define TVC_REGS_SVH

`define TVC_ADDR_MASK 8'ha8
`define TVC_ADDR_PRI_BASE 8'hb8
`define TVC_ADDR_MASK_EXT 8'he6
`define TVC_ADDR_PRI_EXT 8'hf6

`define TVC_RST_MASK 8'h00
`define TVC_RST_PRI 6'h00
`define TVC_RST_MASK_EXT 6'h00
`define TVC_PRI_UNUSED 2'h3
`define TVC_MASK_EXT_UNUSED 2'h0

`define TVC_BIT_GLOBAL 7
`define TVC_BIT_SPARE 6

`define TVC_RST_VEC 16'h0000
`define TVC_VEC_BASE 16'h0003
`define TVC_VEC_LAST 16'h005b
`define TVC_CALL_CYC 3'h4

`endif

// ### test/tvc_periph_model.sv
// Behavioural model of the peripherals' pending flags.
`timescale 1ns/1ps
module tvc_periph_model
  import tvc_pkg::*;
(
  input wire logic i_core_clk, // System clock.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic [16:0] i_set, // Flag set events.
  input wire logic [16:0] i_sw_clr, // Software flag clears.
  input wire logic [3:0] i_flag_clear, // Auto-clear from the controller.
  output tvc_pend_s o_pend // Flags seen by the controller.
);
  logic [16:0] flag_reg;
  // A set wins over a clear in the same cycle, so no event is lost.
  assign o_pend = tvc_pend_s'(flag_reg | i_set);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_reg <= 17'h00000;
    end else begin
      flag_reg <= (flag_reg & ~i_sw_clr & ~{13'h0000, i_flag_clear}) | i_set;
    end
  end
endmodule : tvc_periph_model

// ### test/two_level_vectored_interrupt_ctrl_tb_top.sv
// Self-checking bench of the vectored interrupt controller.
`timescale 1ns/1ps
module two_level_vectored_interrupt_ctrl_tb_top;
  import tvc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic we = 1'b0;
  logic re = 1'b0;
  logic iend = 1'b1;
  logic return_from_service = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [16:0] setv = 17'h00000;
  logic [16:0] sclr = 17'h00000;
  logic [7:0] rdata;
  logic cstart;
  logic cact;
  logic [15:0] vec;
  logic [3:0] fclr;
  logic [1:0] insvc;
  tvc_pend_s pend;
  int err_count = 0;
  int comparisons = 0;
  int k;
  logic [31:0] seed = 32'h4e0c;
  logic [31:0] r;
  logic [11:0] e;
  logic [11:0] p;
  // Flag driven per source; multi-flag sources use a later flag of their group.
  int fidx[12] = '{0, 1, 2, 3, 5, 7, 8, 9, 10, 12, 15, 16};

  tvc_ctrl dut_u (.i_core_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_we(we),
    .i_sfr_re(re), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_pend(pend),
    .i_instr_end(iend), .i_return_from_service(return_from_service), .o_call_start(cstart), .o_call_active(cact),
    .o_vec_addr(vec), .o_flag_clear(fclr), .o_in_service(insvc));
  tvc_periph_model model_u (.i_core_clk(clk), .i_rst(rst), .i_set(setv),
    .i_sw_clr(sclr), .i_flag_clear(fclr), .o_pend(pend));

  initial begin
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic int exp_src(logic [11:0] en, logic [11:0] hi);
    logic [11:0] c;
    c = (|(en & hi)) ? (en & hi) : en;
    for (int i = 11; i >= 0; i--) begin
      if (c[i]) begin
        exp_src = i;
      end
    end
  endfunction : exp_src

  task automatic results();
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    we = 1'b1;
    tick();
    we = 1'b0;
    tick();
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    addr = a;
    re = 1'b1;
    tick();
    re = 1'b0;
    chk("read data", {8'h00, exp}, {8'h00, rdata});
    tick();
  endtask : rd

  task automatic set_en(logic [11:0] en, logic g);
    wr(8'he6, {2'b00, en[11:6]});
    wr(8'ha8, {g, 1'b0, en[5:0]});
  endtask : set_en

  task automatic set_pri(logic [11:0] hi);
    wr(8'hb8, {2'b00, hi[5:0]});
    wr(8'hf6, {2'b00, hi[11:6]});
  endtask : set_pri

  task automatic pulse(int idx);
    setv[idx] = 1'b1;
    tick();
    setv = 17'h00000;
  endtask : pulse

  task automatic clr_all();
    sclr = 17'h1ffff;
    tick();
    sclr = 17'h00000;
  endtask : clr_all

  task automatic wait_call(output int n);
    n = 0;
    while (cstart !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
  endtask : wait_call

  task automatic ret();
    int w = 0;
    while (cact === 1'b1 && w < 10) begin
      tick();
      w++;
    end
    return_from_service = 1'b1;
    tick();
    return_from_service = 1'b0;
  endtask : ret

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("reset vector", 16'h0000, vec);
    chk("reset outputs", 16'h0, {8'h00, fclr, insvc, cstart, cact});
    rd(8'ha8, 8'h00);
    rd(8'hb8, 8'hc0);
    rd(8'he6, 8'h00);
    rd(8'hf6, 8'hc0);
    rd(8'h55, 8'h00);
    r = rnd();
    wr(8'ha8, r[7:0]);
    rd(8'ha8, r[7:0]);
    wr(8'he6, 8'hff);
    rd(8'he6, 8'h3f);
    for (int n = 0; n < 12; n++) begin
      set_en(12'h001 << n, 1'b1);
      pulse(fidx[n]);
      wait_call(k);
      chk("latency", 16'd1, k[15:0]);
      chk("vector", 16'h0003 + 16'(8 * n), vec);
      chk("auto clear", n < 4 ? 16'(4'h1 << n) : 16'h0, {12'h000, fclr});
      chk("in service", 16'h1, {14'h0, insvc});
      k = 0;
      while (cact === 1'b1 && k < 10) begin
        tick();
        k++;
      end
      chk("call length", 16'd4, k[15:0]);
      chk("flag kept", 16'(n >= 4), {15'h0, pend[fidx[n]]});
      ret();
      if (n >= 4) begin
        wait_call(k);
        chk("re-entry", 16'h0003 + 16'(8 * n), vec);
        clr_all();
        ret();
      end
    end
    set_en(12'hfff, 1'b0);
    pulse(0);
    wait_call(k);
    chk("masked call", 16'd40, k[15:0]);
    set_en(12'hfff, 1'b1);
    wait_call(k);
    chk("late vector", 16'h0003, vec);
    ret();
    repeat (6) begin
      r = rnd();
      e = r[11:0] | 12'h800;
      p = r[27:16];
      set_pri(p);
      set_en(e, 1'b1);
      setv = 17'h1ffff;
      tick();
      setv = 17'h00000;
      wait_call(k);
      chk("arbitrated", 16'h0003 + 16'(8 * exp_src(e, p)), vec);
      chk("level", p[exp_src(e, p)] ? 16'h2 : 16'h1, {14'h0, insvc});
      clr_all();
      ret();
      chk("released", 16'h0, {14'h0, insvc});
    end
    set_pri(12'h008);
    set_en(12'h00f, 1'b1);
    pulse(0);
    wait_call(k);
    pulse(2);
    wait_call(k);
    chk("equal wait", 16'd40, k[15:0]);
    pulse(3);
    wait_call(k);
    chk("preempt", 16'h001b, vec);
    chk("both levels", 16'h3, {14'h0, insvc});
    pulse(1);
    wait_call(k);
    chk("no preempt", 16'd40, k[15:0]);
    ret();
    chk("low left", 16'h1, {14'h0, insvc});
    tick();
    ret();
    iend = 1'b0;
    wait_call(k);
    chk("instr wait", 16'd40, k[15:0]);
    iend = 1'b1;
    wait_call(k);
    chk("after return", 16'd1, k[15:0]);
    chk("order", 16'h000b, vec);
    ret();
    wait_call(k);
    chk("next", 16'h0013, vec);
    ret();
    set_pri(12'hfff);
    rst = 1'b1;
    tick();
    rst = 1'b0;
    chk("mid reset vector", 16'h0000, vec);
    rd(8'hf6, 8'hc0);
    rd(8'hb8, 8'hc0);
    results();
  end
endmodule : two_level_vectored_interrupt_ctrl_tb_top
